// file: inc/rbsp_pkg.sv
package rbsp_pkg;

  // Synchroniser lanes for the asynchronous pins
  localparam int RBSP_NPIN = 2;
  localparam int RBSP_IDX_RESET = 0;
  localparam int RBSP_IDX_TRST = 1;
  localparam logic [RBSP_NPIN-1:0] RBSP_SYNC_RST = 2'h0;

  // Cycle counts at 100 MHz
  localparam int RBSP_CNT_W = 8;
  localparam logic [RBSP_CNT_W-1:0] RBSP_POR_CYCLES = 8'h40;
  localparam logic [RBSP_CNT_W-1:0] RBSP_RELEASE_CYCLES = 8'h20;
  localparam logic [RBSP_CNT_W-1:0] RBSP_CNT_ZERO = 8'h00;
  localparam logic [RBSP_CNT_W-1:0] RBSP_CNT_ONE = 8'h01;

  // Strap levels as bonded inside the package
  localparam logic RBSP_EXT_BOOT_TIE = 1'h0;
  localparam logic RBSP_EXT_MEM_TIE = 1'h0;

  typedef enum logic [1:0] {
    RBSP_HOLD = 2'h0,
    RBSP_COUNT = 2'h1,
    RBSP_RUN = 2'h3
  } rbsp_state_t;

endpackage

// file: rtl/rbsp_boot_sel.sv
`timescale 1ns/10ps
module rbsp_boot_sel
  import rbsp_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, active high
  input wire logic capture, // One-cycle pulse at reset release
  input wire logic external_boot_strap, // Boot source strap
  input wire logic external_memory_strap, // Memory mode strap
  input wire logic flash_secured, // Flash security state
  output logic ext_boot_ff, // External boot selected
  output logic flash_open_ff, // Flash unsecured at last release
  output logic ext_mem_wide_ff // Memory strap honoured
);

  logic nxt_ext_boot;
  logic nxt_flash_open;
  logic nxt_ext_mem_wide;

  // Sampled only at release, so a later change of security waits for reset
  always_comb
  begin
    nxt_ext_boot = ext_boot_ff;
    nxt_flash_open = flash_open_ff;
    nxt_ext_mem_wide = ext_mem_wide_ff;
    if (capture)
    begin
      nxt_flash_open = ~flash_secured;
      nxt_ext_boot = external_boot_strap & ~flash_secured;
      nxt_ext_mem_wide = external_boot_strap & ~flash_secured
        & external_memory_strap;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_boot_ff <= 1'h0;
      flash_open_ff <= 1'h0;
      ext_mem_wide_ff <= 1'h0;
    end
    else
    begin
      ext_boot_ff <= nxt_ext_boot;
      flash_open_ff <= nxt_flash_open;
      ext_mem_wide_ff <= nxt_ext_mem_wide;
    end
  end

endmodule // rbsp_boot_sel

// file: rtl/rbsp_top.sv
`timescale 1ns/10ps
module rbsp_top
  import rbsp_pkg::*;
(
  input wire logic CLK, // System clock, 100 MHz
  input wire logic RST, // Power-on, async, active high
  input wire logic RESET_N_PIN, // External reset pin, active low
  input wire logic TRST_N_PIN, // JTAG reset pin, active low
  input wire logic FLASH_SECURED, // Flash security state, level
  input wire logic PULLUP_DISABLE_RESET, // Reset-pin pull-up off
  input wire logic BOOT_STRAP_PULLUP_DISABLE, // Boot strap pull-up off
  input wire logic EXT_MEM_STRAP_PULLUP_DISABLE, // Memory strap pull-up off
  output logic CORE_RST, // Internal core reset, active high
  output logic RESET_OUT_PIN, // Reset output, high while in reset
  output logic DEBUG_RST, // JTAG and debug module reset
  output logic PULLUP_EN_RESET, // Reset-pin pull-up enable
  output logic PULLUP_EN_BOOT, // Boot strap pull-up enable
  output logic PULLUP_EN_EXT_MEM, // Memory strap pull-up enable
  output logic BOOT_EXTERNAL, // Boot from off-chip memory
  output logic BOOT_FLASH_OPEN, // Flash unsecured at release
  output logic EXT_MEM_MODE // Memory strap in effect
);

  logic [RBSP_NPIN-1:0] pin_in;
  logic [RBSP_NPIN-1:0] sync1_ff;
  logic [RBSP_NPIN-1:0] sync2_ff;
  logic [RBSP_NPIN-1:0] sync3_ff;
  logic [RBSP_NPIN-1:0] pin_ff;
  logic [RBSP_NPIN-1:0] nxt_pin;

  logic [RBSP_CNT_W-1:0] por_cnt_ff;
  logic [RBSP_CNT_W-1:0] nxt_por_cnt;
  logic por_active;

  rbsp_state_t state_ff;
  rbsp_state_t nxt_state;
  logic [RBSP_CNT_W-1:0] rel_cnt_ff;
  logic [RBSP_CNT_W-1:0] nxt_rel_cnt;
  logic ext_rst;
  logic any_rst;
  logic release_pulse;

  logic core_rst_ff;
  logic nxt_core_rst;
  logic rst_out_ff;
  logic nxt_rst_out;
  logic dbg_rst_ff;
  logic nxt_dbg_rst;

  logic pu_reset_ff;
  logic pu_boot_ff;
  logic pu_mem_ff;
  logic nxt_pu_reset;
  logic nxt_pu_boot;
  logic nxt_pu_mem;

  logic ext_boot;
  logic flash_open;
  logic ext_mem_wide;

  assign pin_in[RBSP_IDX_RESET] = RESET_N_PIN;
  assign pin_in[RBSP_IDX_TRST] = TRST_N_PIN;

  // Three-stage synchronisers; a level is taken only once stages two and
  // three agree, which also rejects a single-cycle glitch on the pin.
  // Reset value zero means both pins read as asserted until proven high.
  genvar gi;
  generate
    for (gi = 0; gi < RBSP_NPIN; gi++)
    begin : g_sync
      always_comb
      begin
        nxt_pin[gi] = pin_ff[gi];
        if (sync2_ff[gi] == sync3_ff[gi])
        begin
          nxt_pin[gi] = sync2_ff[gi];
        end
      end

      always_ff @(posedge CLK or posedge RST)
      begin
        if (RST)
        begin
          sync1_ff[gi] <= RBSP_SYNC_RST[gi];
          sync2_ff[gi] <= RBSP_SYNC_RST[gi];
          sync3_ff[gi] <= RBSP_SYNC_RST[gi];
          pin_ff[gi] <= RBSP_SYNC_RST[gi];
        end
        else
        begin
          sync1_ff[gi] <= pin_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
          pin_ff[gi] <= nxt_pin[gi];
        end
      end
    end
  endgenerate

  assign ext_rst = ~pin_ff[RBSP_IDX_RESET];

  // Power-on stretch: RST is the supply detector, held further by a count
  assign por_active = (por_cnt_ff != RBSP_POR_CYCLES);

  always_comb
  begin
    nxt_por_cnt = por_cnt_ff;
    if (por_active)
    begin
      nxt_por_cnt = por_cnt_ff + RBSP_CNT_ONE;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      por_cnt_ff <= RBSP_CNT_ZERO;
    end
    else
    begin
      por_cnt_ff <= nxt_por_cnt;
    end
  end

  assign any_rst = ext_rst | por_active;

  // Release sequencer; any reset source during the count restarts it
  always_comb
  begin
    nxt_state = state_ff;
    nxt_rel_cnt = rel_cnt_ff;
    case (state_ff)
      RBSP_HOLD:
      begin
        nxt_rel_cnt = RBSP_CNT_ZERO;
        if (!any_rst)
        begin
          nxt_state = RBSP_COUNT;
        end
      end
      RBSP_COUNT:
      begin
        if (any_rst)
        begin
          nxt_state = RBSP_HOLD;
          nxt_rel_cnt = RBSP_CNT_ZERO;
        end
        else if (rel_cnt_ff == RBSP_RELEASE_CYCLES - RBSP_CNT_ONE)
        begin
          nxt_state = RBSP_RUN;
        end
        else
        begin
          nxt_rel_cnt = rel_cnt_ff + RBSP_CNT_ONE;
        end
      end
      RBSP_RUN:
      begin
        if (any_rst)
        begin
          nxt_state = RBSP_HOLD;
          nxt_rel_cnt = RBSP_CNT_ZERO;
        end
      end
      default:
      begin
        nxt_state = RBSP_HOLD;
        nxt_rel_cnt = RBSP_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_ff <= RBSP_HOLD;
      rel_cnt_ff <= RBSP_CNT_ZERO;
    end
    else
    begin
      state_ff <= nxt_state;
      rel_cnt_ff <= nxt_rel_cnt;
    end
  end

  assign release_pulse = (state_ff == RBSP_COUNT) && (nxt_state == RBSP_RUN);

  // Reset outputs; the debug reset ignores the device reset pin so a
  // debugger can keep its session across a core reset
  always_comb
  begin
    nxt_core_rst = (nxt_state != RBSP_RUN);
    nxt_rst_out = (nxt_state != RBSP_RUN);
    nxt_dbg_rst = por_active | ~pin_ff[RBSP_IDX_TRST];
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      core_rst_ff <= 1'h1;
      rst_out_ff <= 1'h1;
      dbg_rst_ff <= 1'h1;
    end
    else
    begin
      core_rst_ff <= nxt_core_rst;
      rst_out_ff <= nxt_rst_out;
      dbg_rst_ff <= nxt_dbg_rst;
    end
  end

  // Pull-ups come back on during reset, since the disable bits belong to
  // logic that is itself being reset
  always_comb
  begin
    nxt_pu_reset = 1'h1;
    nxt_pu_boot = 1'h1;
    nxt_pu_mem = 1'h1;
    if (!core_rst_ff)
    begin
      nxt_pu_reset = ~PULLUP_DISABLE_RESET;
      nxt_pu_boot = ~BOOT_STRAP_PULLUP_DISABLE;
      nxt_pu_mem = ~EXT_MEM_STRAP_PULLUP_DISABLE;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      pu_reset_ff <= 1'h1;
      pu_boot_ff <= 1'h1;
      pu_mem_ff <= 1'h1;
    end
    else
    begin
      pu_reset_ff <= nxt_pu_reset;
      pu_boot_ff <= nxt_pu_boot;
      pu_mem_ff <= nxt_pu_mem;
    end
  end

  // Straps are bonded low, so boot is always internal on this package
  rbsp_boot_sel u_boot_sel (
    .clk (CLK),
    .rst (RST),
    .capture (release_pulse),
    .external_boot_strap (RBSP_EXT_BOOT_TIE),
    .external_memory_strap (RBSP_EXT_MEM_TIE),
    .flash_secured (FLASH_SECURED),
    .ext_boot_ff (ext_boot),
    .flash_open_ff (flash_open),
    .ext_mem_wide_ff (ext_mem_wide)
  );

  assign CORE_RST = core_rst_ff;
  assign RESET_OUT_PIN = rst_out_ff;
  assign DEBUG_RST = dbg_rst_ff;
  assign PULLUP_EN_RESET = pu_reset_ff;
  assign PULLUP_EN_BOOT = pu_boot_ff;
  assign PULLUP_EN_EXT_MEM = pu_mem_ff;
  assign BOOT_EXTERNAL = ext_boot;
  assign BOOT_FLASH_OPEN = flash_open;
  assign EXT_MEM_MODE = ext_mem_wide;

endmodule // rbsp_top

// file: testbench/rbsp_properties.sv
`timescale 1ns/10ps
module rbsp_properties (
  input wire logic CLK, // Clock
  input wire logic RST, // Power-on
  input wire logic RESET_N_PIN, // Pin
  input wire logic TRST_N_PIN, // Pin
  input wire logic FLASH_SECURED, // Level
  input wire logic PULLUP_DISABLE_RESET, // Bit
  input wire logic BOOT_STRAP_PULLUP_DISABLE, // Bit
  input wire logic EXT_MEM_STRAP_PULLUP_DISABLE, // Bit
  input wire logic CORE_RST, // Out
  input wire logic RESET_OUT_PIN, // Out
  input wire logic DEBUG_RST, // Out
  input wire logic PULLUP_EN_RESET, // Out
  input wire logic PULLUP_EN_BOOT, // Out
  input wire logic PULLUP_EN_EXT_MEM, // Out
  input wire logic BOOT_EXTERNAL, // Out
  input wire logic BOOT_FLASH_OPEN, // Out
  input wire logic EXT_MEM_MODE // Out
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Cycles since power-on and since the pin last read low, saturating
  logic [7:0] up_ff;
  logic [7:0] hi_ff;
  always_ff @(posedge CLK or posedge RST)
    if (RST)
    begin
      up_ff <= 8'h00;
      hi_ff <= 8'h00;
    end
    else
    begin
      up_ff <= up_ff + {7'h0, up_ff != 8'hff};
      hi_ff <= RESET_N_PIN ? hi_ff + {7'h0, hi_ff != 8'hff} : 8'h00;
    end
  out_mirror_a: assert property (RESET_OUT_PIN == CORE_RST)
    else $error("reset out differs");
  ext_hold_a: assert property (!RESET_N_PIN [*8] |-> CORE_RST)
    else $error("pin low without reset");
  por_hold_a: assert property (up_ff <= 8'h40 |-> CORE_RST)
    else $error("power-on reset short");
  rel_wait_a: assert property ($fell(CORE_RST) |-> hi_ff >= 8'h20)
    else $error("release too early");
  rel_bound_a: assert property (hi_ff == 8'h78 |-> !CORE_RST)
    else $error("release too late");
  dbg_set_a: assert property (!TRST_N_PIN [*8] |-> DEBUG_RST)
    else $error("debug reset missing");
  // Count threshold lies past the power-on stretch so the check is live
  dbg_keep_a: assert property (
    TRST_N_PIN [*8] ##0 up_ff >= 8'h50 |-> !DEBUG_RST)
    else $error("debug reset disturbed");
  pull_force_a: assert property (CORE_RST [*2] |->
    PULLUP_EN_RESET && PULLUP_EN_BOOT && PULLUP_EN_EXT_MEM)
    else $error("pull-up off in reset");
  pull_rst_a: assert property (!CORE_RST [*3] ##0
    $stable(PULLUP_DISABLE_RESET)
    |-> PULLUP_EN_RESET != PULLUP_DISABLE_RESET)
    else $error("reset pull-up wrong");
  pull_strap_a: assert property (!CORE_RST [*3] ##0
    $stable({BOOT_STRAP_PULLUP_DISABLE, EXT_MEM_STRAP_PULLUP_DISABLE})
    |-> PULLUP_EN_BOOT != BOOT_STRAP_PULLUP_DISABLE
    && PULLUP_EN_EXT_MEM != EXT_MEM_STRAP_PULLUP_DISABLE)
    else $error("strap pull-up wrong");
  boot_int_a: assert property (!BOOT_EXTERNAL && !EXT_MEM_MODE)
    else $error("external boot seen");
  flash_cap_a: assert property ($fell(CORE_RST)
    |-> BOOT_FLASH_OPEN != $past(FLASH_SECURED))
    else $error("flash state not captured");
  flash_keep_a: assert property (!CORE_RST && !$past(CORE_RST)
    |-> $stable(BOOT_FLASH_OPEN))
    else $error("flash state moved");
endmodule // rbsp_properties
bind rbsp_top rbsp_properties chk (.*);

// file: testbench/rbsp_board.sv
`timescale 1ns/10ps
module rbsp_board (
  hold_rst, // Press reset
  hold_trst, // Debugger reset
  rst_n_line, // Reset line
  trst_n_line // JTAG line
);
  input wire logic hold_rst;
  input wire logic hold_trst;
  output logic rst_n_line;
  output logic trst_n_line;
  // Board pull-ups hold both lines high once released
  assign rst_n_line = !hold_rst;
  assign trst_n_line = !hold_trst;
endmodule // rbsp_board

// file: testbench/tb.sv
`timescale 1ns/10ps
module tb;
  logic clk = 0, rst = 1, hr = 0, ht = 0, fs = 0;
  logic pr = 0, pb = 0, pm = 0;
  logic rn, tn, core, ro, dbg, er, eb, em, bx, bf, mm;
  int n_fail = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  rbsp_board brd (.hold_rst(hr), .hold_trst(ht), .rst_n_line(rn),
    .trst_n_line(tn));
  rbsp_top uut (.CLK(clk), .RST(rst), .RESET_N_PIN(rn), .TRST_N_PIN(tn),
    .FLASH_SECURED(fs), .PULLUP_DISABLE_RESET(pr),
    .BOOT_STRAP_PULLUP_DISABLE(pb), .EXT_MEM_STRAP_PULLUP_DISABLE(pm),
    .CORE_RST(core), .RESET_OUT_PIN(ro), .DEBUG_RST(dbg),
    .PULLUP_EN_RESET(er), .PULLUP_EN_BOOT(eb), .PULLUP_EN_EXT_MEM(em),
    .BOOT_EXTERNAL(bx), .BOOT_FLASH_OPEN(bf), .EXT_MEM_MODE(mm));
  task chk(input string s, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", s, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait for core reset release
  task rel(output int n);
    n = 0;
    while (core !== 1'b0 && n < 300)
    begin
      cyc(1);
      n++;
    end
  endtask
  task t_por;
    int n;
    cyc(60);
    chk("core", 1, core);
    rel(n);
    chk("wait", 1, n >= 36 && n <= 40);
    chk("out", 0, ro);
    chk("boot", 0, bx | mm);
    chk("open", 1, bf);
    cyc(4);
    chk("dbg", 0, dbg);
    $display("por done");
  endtask
  task t_pull;
    {pr, pb, pm} = 3'h7;
    cyc(2);
    chk("pu_rst", 0, er);
    chk("pu_strap", 0, eb | em);
    $display("pull done");
  endtask
  task t_pin;
    int n;
    fs = 1;
    hr = 1;
    cyc(10);
    chk("core", 1, core);
    chk("out", 1, ro);
    chk("dbg", 0, dbg);
    chk("pu", 1, er & eb & em);
    hr = 0;
    rel(n);
    chk("wait", 1, n >= 32 && n <= 40);
    chk("open", 0, bf);
    $display("pin done");
  endtask
  task t_full;
    int n;
    hr = 1;
    ht = 1;
    cyc(10);
    chk("dbg", 1, dbg);
    rst = 1;
    cyc(1);
    rst = 0;
    cyc(10);
    chk("por", 1, core);
    {hr, ht} = 2'h0;
    rel(n);
    chk("hold", 1, n >= 80 && n <= 100);
    chk("rel", 0, core);
    $display("full done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(4);
    rst = 0;
    t_por;
    t_pull;
    t_pin;
    t_full;
    conclude;
  end
  initial
  begin
    #20000;
    n_fail++;
    conclude;
  end
endmodule // tb
